// *** hdl/alu_regs.vh ***
// Operation codes, size codes and flag reset values for the logic, shift and bit datapath.
`ifndef ALU_REGS_VH
`define ALU_REGS_VH
`define OP_W 5
`define OP_AND 5'h00
`define OP_OR 5'h01
`define OP_XOR 5'h02
`define OP_NOT 5'h03
`define OP_ARITH_SHIFT_LEFT 5'h04
`define OP_ARITH_SHIFT_RIGHT 5'h05
`define OP_LOGIC_SHIFT_LEFT 5'h06
`define OP_LOGIC_SHIFT_RIGHT 5'h07
`define OP_ROTATE_LEFT 5'h08
`define OP_ROTATE_RIGHT 5'h09
`define OP_ROTATE_LEFT_VIA_CARRY 5'h0a
`define OP_ROTATE_RIGHT_VIA_CARRY 5'h0b
`define OP_BIT_SET 5'h0c
`define OP_BIT_CLEAR 5'h0d
`define OP_BIT_INVERT 5'h0e
`define OP_BIT_TEST 5'h0f
`define OP_CARRY_AND_BIT 5'h10
`define OP_CARRY_AND_INV_BIT 5'h11
`define OP_CARRY_OR_BIT 5'h12
`define OP_CARRY_OR_INV_BIT 5'h13
`define OP_CARRY_XOR_BIT 5'h14
`define OP_CARRY_XOR_INV_BIT 5'h15
`define OP_BIT_TO_CARRY 5'h16
`define OP_INV_BIT_TO_CARRY 5'h17
`define OP_CARRY_TO_BIT 5'h18
`define OP_INV_CARRY_TO_BIT 5'h19
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define CARRY_RST 1'h0
`define ZERO_RST 1'h0
`endif

// *** hdl/size_mask.v ***
// Operand width mask and sign bit position for byte, word and longword sizes.
`timescale 1ns/100ps
`include "alu_regs.vh"
module size_mask (
  input wire [1:0] size_i, // Operand size code.
  input wire [31:0] value_i, // Value to inspect.
  output reg [31:0] mask_o, // Ones over the operand width.
  output reg msb_o // Top bit of the operand.
);

  // Byte is the fallback so an unknown size never touches the upper bits.
  always @* begin
    case (size_i)
      `SIZE_WORD: begin
        mask_o = 32'h0000ffff;
        msb_o = value_i[15];
      end
      `SIZE_LONG: begin
        mask_o = 32'hffffffff;
        msb_o = value_i[31];
      end
      default: begin
        mask_o = 32'h000000ff;
        msb_o = value_i[7];
      end
    endcase
  end
endmodule // size_mask

// *** hdl/bit_unit.v ***
// Single-bit manipulation on a byte operand.
`timescale 1ns/100ps
`include "alu_regs.vh"
module bit_unit (
  input wire [4:0] op_i, // Operation code.
  input wire [7:0] byte_i, // Byte operand.
  input wire [2:0] idx_i, // Bit index.
  input wire carry_i, // Current carry flag.
  output reg [7:0] byte_o, // Modified byte.
  output reg bit_o // Selected bit as read.
);

  reg [7:0] sel;

  // One-hot select of the target bit; other bits pass through untouched.
  always @* begin
    sel = 8'h01 << idx_i;
    bit_o = byte_i[idx_i];
    case (op_i)
      `OP_BIT_SET: byte_o = byte_i | sel; // [RULE_10]
      `OP_BIT_CLEAR: byte_o = byte_i & ~sel; // [RULE_11]
      `OP_BIT_INVERT: byte_o = byte_i ^ sel; // [RULE_12]
      `OP_CARRY_TO_BIT: byte_o = carry_i ? (byte_i | sel) : (byte_i & ~sel); // [RULE_20]
      `OP_INV_CARRY_TO_BIT: byte_o = carry_i ? (byte_i & ~sel) : (byte_i | sel); // [RULE_21]
      default: byte_o = byte_i;
    endcase
  end
endmodule // bit_unit

// *** hdl/logic_shift_bit_alu.v ***
// Logic, shift, rotate and bit manipulation datapath with carry and zero flags.
// How it works
// RULE_01: AND destination with source, write destination.
// RULE_02: OR destination with source, write destination.
// RULE_03: XOR destination with source, write destination.
// RULE_04: Complement every bit of destination.
// RULE_05: Arithmetic shift left or right in place.
// RULE_06: Logical shift left or right in place.
// RULE_07: Rotate within operand width in place.
// RULE_08: Rotate through carry as extra bit.
// RULE_09: Bit index from immediate or register.
// RULE_10: Bit set forces indexed bit to one.
// RULE_11: Bit clear forces indexed bit to zero.
// RULE_12: Bit invert toggles indexed bit.
// RULE_13: Bit test puts inverted bit in zero.
// RULE_14: Carry ANDed with indexed bit.
// RULE_15: Carry ORed with indexed bit.
// RULE_16: Carry XORed with indexed bit.
// RULE_17: Inverted-bit variants use immediate index only.
// RULE_18: Indexed bit copied into carry.
// RULE_19: Inverted bit into carry, immediate index.
// RULE_20: Carry written into indexed bit.
// RULE_21: Inverted carry into bit, immediate index.
// RULE_22: Byte/word/long for logic; bits byte only.
// RULE_23: Shifts move one place, out-bit to carry.
`timescale 1ns/100ps
`include "alu_regs.vh"
module logic_shift_bit_alu (
  input wire clock_i, // CPU clock.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire start_i, // Decoder issues an operation this cycle.
  input wire [4:0] op_i, // Operation code.
  input wire [1:0] size_i, // Operand size code.
  input wire [31:0] dest_i, // Destination register or memory byte.
  input wire [31:0] source_register_i, // Source register value.
  input wire [31:0] immediate_value_i, // Immediate data.
  input wire use_imm_i, // Take source from immediate data.
  input wire [2:0] bit_imm_i, // Immediate bit index.
  input wire bit_idx_from_reg_i, // Take bit index from source register.
  input wire carry_i, // Carry flag from condition codes.
  input wire zero_i, // Zero flag from condition codes.
  output reg [31:0] result_o, // Value to write back.
  output reg result_we_o, // Write result to destination, one cycle.
  output reg carry_o, // Updated carry flag.
  output reg carry_we_o, // Carry update strobe, one cycle.
  output reg zero_o, // Updated zero flag.
  output reg zero_we_o, // Zero update strobe, one cycle.
  output reg done_o // Operation complete, one cycle.
);

  ////////////////////////////////////////////////////////////////////////////
  // Operand width and shared bit unit.

  wire [31:0] mask;
  wire msb;
  wire [31:0] dmask;
  wire [1:0] eff_size;
  wire [7:0] bit_byte;
  wire bit_val;
  reg [2:0] bit_idx;
  reg [31:0] src;
  reg is_bit_op;
  reg imm_only;

  // Bit operations are byte wide whatever size the decoder sends.
  assign eff_size = is_bit_op ? `SIZE_BYTE : size_i; // [RULE_22]
  assign dmask = dest_i & mask;

  size_mask u_size_mask (
    .size_i(eff_size),
    .value_i(dest_i),
    .mask_o(mask),
    .msb_o(msb)
  );

  bit_unit u_bit_unit (
    .op_i(op_i),
    .byte_i(dest_i[7:0]),
    .idx_i(bit_idx),
    .carry_i(carry_i),
    .byte_o(bit_byte),
    .bit_o(bit_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operand and index selection.

  // Inverted variants ignore the register index, so a stray select cannot alter them.
  always @* begin
    is_bit_op = (op_i >= `OP_BIT_SET) && (op_i <= `OP_INV_CARRY_TO_BIT);
    imm_only = (op_i == `OP_CARRY_AND_INV_BIT) || (op_i == `OP_CARRY_OR_INV_BIT) ||
               (op_i == `OP_CARRY_XOR_INV_BIT) || (op_i == `OP_INV_BIT_TO_CARRY) ||
               (op_i == `OP_INV_CARRY_TO_BIT); // [RULE_17] [RULE_19] [RULE_21]
    if (bit_idx_from_reg_i && !imm_only) begin
      bit_idx = source_register_i[2:0]; // [RULE_09]
    end else begin
      bit_idx = bit_imm_i; // [RULE_09]
    end
    src = use_imm_i ? immediate_value_i : source_register_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combinational result.

  reg [31:0] res_d;
  reg res_we_d;
  reg c_d;
  reg c_we_d;
  reg z_d;
  reg z_we_d;

  // Upper bits outside the operand width are kept so narrow writes are safe.
  always @* begin
    res_d = dest_i;
    res_we_d = 1'b0;
    c_d = carry_i;
    c_we_d = 1'b0;
    z_d = zero_i;
    z_we_d = 1'b0;
    case (op_i)
      `OP_AND: begin
        res_d = (dest_i & ~mask) | (dest_i & src & mask); // [RULE_01]
        res_we_d = 1'b1;
      end
      `OP_OR: begin
        res_d = (dest_i & ~mask) | ((dest_i | src) & mask); // [RULE_02]
        res_we_d = 1'b1;
      end
      `OP_XOR: begin
        res_d = (dest_i & ~mask) | ((dest_i ^ src) & mask); // [RULE_03]
        res_we_d = 1'b1;
      end
      `OP_NOT: begin
        res_d = dest_i ^ mask; // [RULE_04]
        res_we_d = 1'b1;
      end
      `OP_ARITH_SHIFT_LEFT, `OP_LOGIC_SHIFT_LEFT: begin
        res_d = (dest_i & ~mask) | ({dmask[30:0], 1'b0} & mask); // [RULE_05] [RULE_06]
        res_we_d = 1'b1;
        c_d = msb; // [RULE_23]
        c_we_d = 1'b1;
      end
      `OP_ARITH_SHIFT_RIGHT: begin
        res_d = (dest_i & ~mask) | (({1'b0, dmask[31:1]} | (msb ? (mask ^ (mask >> 1)) : 32'h0)) & mask); // [RULE_05]
        res_we_d = 1'b1;
        c_d = dest_i[0]; // [RULE_23]
        c_we_d = 1'b1;
      end
      `OP_LOGIC_SHIFT_RIGHT: begin
        res_d = (dest_i & ~mask) | {1'b0, dmask[31:1]}; // [RULE_06]
        res_we_d = 1'b1;
        c_d = dest_i[0]; // [RULE_23]
        c_we_d = 1'b1;
      end
      `OP_ROTATE_LEFT: begin
        res_d = (dest_i & ~mask) | (({dmask[30:0], 1'b0} | {31'h0, msb}) & mask); // [RULE_07]
        res_we_d = 1'b1;
        c_d = msb; // [RULE_23]
        c_we_d = 1'b1;
      end
      `OP_ROTATE_RIGHT: begin
        res_d = (dest_i & ~mask) | (({1'b0, dmask[31:1]} | (dest_i[0] ? (mask ^ (mask >> 1)) : 32'h0)) & mask); // [RULE_07]
        res_we_d = 1'b1;
        c_d = dest_i[0]; // [RULE_23]
        c_we_d = 1'b1;
      end
      `OP_ROTATE_LEFT_VIA_CARRY: begin
        res_d = (dest_i & ~mask) | (({dmask[30:0], 1'b0} | {31'h0, carry_i}) & mask); // [RULE_08]
        res_we_d = 1'b1;
        c_d = msb; // [RULE_08] [RULE_23]
        c_we_d = 1'b1;
      end
      `OP_ROTATE_RIGHT_VIA_CARRY: begin
        res_d = (dest_i & ~mask) | (({1'b0, dmask[31:1]} | (carry_i ? (mask ^ (mask >> 1)) : 32'h0)) & mask); // [RULE_08]
        res_we_d = 1'b1;
        c_d = dest_i[0]; // [RULE_08] [RULE_23]
        c_we_d = 1'b1;
      end
      `OP_BIT_SET, `OP_BIT_CLEAR, `OP_BIT_INVERT, `OP_CARRY_TO_BIT, `OP_INV_CARRY_TO_BIT: begin
        res_d = {dest_i[31:8], bit_byte}; // [RULE_10] [RULE_11] [RULE_12] [RULE_20] [RULE_21]
        res_we_d = 1'b1;
      end
      `OP_BIT_TEST: begin
        z_d = ~bit_val; // [RULE_13]
        z_we_d = 1'b1;
      end
      `OP_CARRY_AND_BIT: begin
        c_d = carry_i & bit_val; // [RULE_14]
        c_we_d = 1'b1;
      end
      `OP_CARRY_AND_INV_BIT: begin
        c_d = carry_i & ~bit_val; // [RULE_17]
        c_we_d = 1'b1;
      end
      `OP_CARRY_OR_BIT: begin
        c_d = carry_i | bit_val; // [RULE_15]
        c_we_d = 1'b1;
      end
      `OP_CARRY_OR_INV_BIT: begin
        c_d = carry_i | ~bit_val; // [RULE_17]
        c_we_d = 1'b1;
      end
      `OP_CARRY_XOR_BIT: begin
        c_d = carry_i ^ bit_val; // [RULE_16]
        c_we_d = 1'b1;
      end
      `OP_CARRY_XOR_INV_BIT: begin
        c_d = carry_i ^ ~bit_val; // [RULE_17]
        c_we_d = 1'b1;
      end
      `OP_BIT_TO_CARRY: begin
        c_d = bit_val; // [RULE_18]
        c_we_d = 1'b1;
      end
      `OP_INV_BIT_TO_CARRY: begin
        c_d = ~bit_val; // [RULE_19]
        c_we_d = 1'b1;
      end
      default: begin
        res_d = dest_i;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // One registered stage: strobes pulse for exactly one cycle per start.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      result_o <= 32'h00000000;
      result_we_o <= 1'b0;
      carry_o <= `CARRY_RST;
      carry_we_o <= 1'b0;
      zero_o <= `ZERO_RST;
      zero_we_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      result_we_o <= start_i & res_we_d;
      carry_we_o <= start_i & c_we_d;
      zero_we_o <= start_i & z_we_d;
      done_o <= start_i;
      if (start_i) begin
        result_o <= res_d;
        carry_o <= c_d;
        zero_o <= z_d;
      end
    end
  end
endmodule // logic_shift_bit_alu

// *** dv/alu_checker.sv ***
// Port checks for the logic, shift and bit datapath.
`timescale 1ns/100ps
`include "alu_regs.vh"
module alu_checker (
  input wire clock_i, // Clock.
  input wire rst_n_i, // Reset.
  input wire start_i, // Issue.
  input wire [4:0] op_i, // Op.
  input wire [1:0] size_i, // Size.
  input wire [31:0] dest_i, // Target.
  input wire [31:0] source_register_i, // Source.
  input wire use_imm_i, // Imm select.
  input wire [2:0] bit_imm_i, // Index.
  input wire bit_idx_from_reg_i, // Index select.
  input wire carry_i, // Carry in.
  input wire [31:0] result_o, // Result.
  input wire result_we_o, // Write.
  input wire carry_o, // Carry.
  input wire carry_we_o, // Carry write.
  input wire zero_o, // Zero.
  input wire zero_we_o // Zero write.
);
  // One clock; a reset abandons any check in flight.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  a_and_byte: assert property (
    start_i && op_i == `OP_AND && size_i == `SIZE_BYTE && !use_imm_i
    |=> result_we_o && result_o == ($past(dest_i) & ($past(source_register_i) | 32'hffffff00)))
    else $error("and wrong");
  a_xor_word: assert property (
    start_i && op_i == `OP_XOR && size_i == `SIZE_WORD && !use_imm_i
    |=> result_o == ($past(dest_i) ^ ($past(source_register_i) & 32'h0000ffff)))
    else $error("xor wrong");
  a_not_byte: assert property (
    start_i && op_i == `OP_NOT && size_i == `SIZE_BYTE
    |=> result_we_o && result_o == ($past(dest_i) ^ 32'h000000ff)) else $error("not wrong");
  a_shift_right: assert property (
    start_i && op_i == `OP_LOGIC_SHIFT_RIGHT && size_i == `SIZE_BYTE
    |=> carry_we_o && carry_o == $past(dest_i[0]) && result_o[7:0] == {1'h0, $past(dest_i[7:1])})
    else $error("shift wrong");
  a_rotate_carry: assert property (
    start_i && op_i == `OP_ROTATE_RIGHT_VIA_CARRY && size_i == `SIZE_BYTE
    |=> carry_o == $past(dest_i[0]) && result_o[7:0] == {$past(carry_i), $past(dest_i[7:1])})
    else $error("rotate wrong");
  a_bit_set: assert property (
    start_i && op_i == `OP_BIT_SET && !bit_idx_from_reg_i
    |=> result_o[7:0] == ($past(dest_i[7:0]) | (8'h01 << $past(bit_imm_i)))) else $error("set wrong");
  a_bit_test: assert property (
    start_i && op_i == `OP_BIT_TEST && !bit_idx_from_reg_i |=> zero_we_o && !result_we_o
    && zero_o == (($past(dest_i) & (32'h1 << $past(bit_imm_i))) == 32'h0)) else $error("test wrong");
  a_load_carry: assert property (
    start_i && op_i == `OP_BIT_TO_CARRY && !bit_idx_from_reg_i |=> carry_we_o
    && carry_o == ((($past(dest_i) >> $past(bit_imm_i)) & 32'h1) != 32'h0)) else $error("load wrong");
endmodule // alu_checker

bind logic_shift_bit_alu alu_checker i_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i), .size_i(size_i),
  .dest_i(dest_i), .source_register_i(source_register_i), .use_imm_i(use_imm_i),
  .bit_imm_i(bit_imm_i), .bit_idx_from_reg_i(bit_idx_from_reg_i), .carry_i(carry_i),
  .result_o(result_o), .result_we_o(result_we_o), .carry_o(carry_o), .carry_we_o(carry_we_o),
  .zero_o(zero_o), .zero_we_o(zero_we_o)
);

// *** dv/testbench.sv ***
// Self-checking bench for the logic, shift and bit datapath.
`timescale 1ns/100ps
module testbench;
  // Row: op, size, index, {mode, carry}, target, source, result, {write, carry, zero} strobes, flag.
  typedef struct packed {
    logic [7:0] op; logic [3:0] sz; logic [3:0] ix; logic [3:0] mc;
    logic [31:0] d; logic [31:0] s; logic [31:0] r; logic [3:0] we; logic [3:0] f;
  } row_t;
  localparam int N = 30;
  row_t rows [0:N-1] = '{
    124'h00_0_0_0_123456a5_ffff0f3c_12345624_4_0, 124'h01_2_0_2_123456a5_80000f00_92345fa5_4_0,
    124'h02_1_0_0_123456a5_0000ffff_1234a95a_4_0, 124'h03_0_0_0_123456a5_00000000_1234565a_4_0,
    124'h04_0_0_0_123456a5_00000000_1234564a_6_1, 124'h05_0_0_0_123456a5_00000000_123456d2_6_1,
    124'h05_2_0_0_823456a4_00000000_c11a2b52_6_0, 124'h06_1_0_0_1234c6a5_00000000_12348d4a_6_1,
    124'h07_0_0_0_123456a5_00000000_12345652_6_1, 124'h08_0_0_0_123456a5_00000000_1234564b_6_1,
    124'h09_0_0_0_123456a5_00000000_123456d2_6_1, 124'h0a_0_0_1_12345625_00000000_1234564b_6_0,
    124'h0b_0_0_1_123456a4_00000000_123456d2_6_0, 124'h0b_2_0_0_00000001_00000000_00000000_6_1,
    124'h0c_0_1_0_123456a5_00000000_123456a7_4_0, 124'h0c_0_6_2_123456a5_00000000_123456e5_4_0,
    124'h0d_2_7_0_123456a5_00000000_12345625_4_0, 124'h0e_0_0_0_123456a5_00000000_123456a4_4_0,
    124'h0f_0_2_0_123456a5_00000000_00000000_1_0, 124'h0f_0_0_2_123456a4_00000000_00000000_1_1,
    124'h10_0_0_1_123456a5_00000000_00000000_2_1, 124'h11_0_0_3_123456a4_00000000_00000000_2_0,
    124'h12_0_5_0_123456a5_00000000_00000000_2_1, 124'h13_0_6_0_123456a5_00000000_00000000_2_1,
    124'h14_0_7_1_123456a5_00000000_00000000_2_0, 124'h15_0_1_0_123456a5_00000000_00000000_2_1,
    124'h16_0_2_0_123456a5_00000000_00000000_2_1, 124'h17_0_4_0_123456a5_00000000_00000000_2_1,
    124'h18_0_4_1_123456a5_00000000_123456b5_4_0, 124'h19_0_0_1_123456a5_00000000_123456a4_4_0};
  logic clock_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic start_i, use_imm_i, bit_idx_from_reg_i, carry_i, zero_i;
  logic [4:0] op_i;
  logic [1:0] size_i;
  logic [31:0] dest_i, source_register_i, immediate_value_i, result_o;
  logic [2:0] bit_imm_i;
  logic result_we_o, carry_o, carry_we_o, zero_o, zero_we_o, done_o;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  ////////////////////////////////////////
  logic_shift_bit_alu i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
    .size_i(size_i), .dest_i(dest_i), .source_register_i(source_register_i),
    .immediate_value_i(immediate_value_i), .use_imm_i(use_imm_i), .bit_imm_i(bit_imm_i),
    .bit_idx_from_reg_i(bit_idx_from_reg_i), .carry_i(carry_i), .zero_i(zero_i), .result_o(result_o),
    .result_we_o(result_we_o), .carry_o(carry_o), .carry_we_o(carry_we_o), .zero_o(zero_o),
    .zero_we_o(zero_we_o), .done_o(done_o));
  // The 40 MHz clock; the run is short, so 500 cycles means a hang.
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 500) begin
      bad_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  // Mode bit turns on immediate data and register index; the unused path gets decoy values.
  task automatic drive(input row_t t, input logic go);
    start_i <= go;
    op_i <= t.op[4:0];
    size_i <= t.sz[1:0];
    dest_i <= t.d;
    use_imm_i <= t.mc[1];
    bit_idx_from_reg_i <= t.mc[1];
    carry_i <= t.mc[0];
    zero_i <= ~t.mc[0];
    source_register_i <= t.mc[1] ? {~t.s[31:3], t.ix[2:0]} : t.s;
    immediate_value_i <= t.mc[1] ? t.s : ~t.s;
    bit_imm_i <= t.mc[1] ? ~t.ix[2:0] : t.ix[2:0];
  endtask
  // Compare strobes, result and flag of one row.
  task automatic check(input row_t t);
    compares++;
    if (done_o !== 1'h1 || {result_we_o, carry_we_o, zero_we_o} !== t.we[2:0]
        || (t.we[2] && result_o !== t.r) || (t.we[1] && carry_o !== t.f[0])
        || (t.we[0] && zero_o !== t.f[0])) begin
      bad_count++;
      $display("unexpected at %0t: op %h gave %h", $time, t.op, result_o);
    end
  endtask
  // Outputs after a reset edge, flags included.
  task automatic check_zero();
    compares++;
    if ({done_o, result_we_o, carry_we_o, zero_we_o, carry_o, zero_o, result_o} !== 38'h0) begin
      bad_count++;
      $display("unexpected at %0t: outputs not cleared", $time);
    end
  endtask
  task automatic finish_test();
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Rows go back to back, so each result is checked while the next op issues.
  initial begin
    drive(rows[0], 1'h0);
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'h1;
    #1 check_zero();
    for (int i = 0; i < N; i++) begin
      @(posedge clock_i);
      drive(rows[i], 1'h1);
      #1;
      if (i > 0) check(rows[i - 1]);
    end
    // An unknown op must leave the target alone and raise no write strobe, only done.
    @(posedge clock_i);
    drive(124'h1f_0_0_0_123456a5_00000000_00000000_0_0, 1'h1);
    #1 check(rows[N - 1]);
    @(posedge clock_i);
    start_i <= 1'h0;
    #1;
    compares++;
    if (done_o !== 1'h1 || result_o !== 32'h123456a5 || {result_we_o, carry_we_o, zero_we_o} !== 3'h0) begin
      bad_count++;
      $display("unexpected at %0t: unknown op acted", $time);
    end
    // A reset in the same edge as an issue wins.
    @(posedge clock_i);
    drive(rows[0], 1'h1);
    rst_n_i <= 1'h0;
    @(posedge clock_i);
    start_i <= 1'h0;
    #1 check_zero();
    @(posedge clock_i);
    rst_n_i <= 1'h1;
    #1 check_zero();
    // The first edge after release still shows cleared outputs; an op issued there must work.
    @(posedge clock_i);
    drive(rows[3], 1'h1);
    #1 check_zero();
    @(posedge clock_i);
    start_i <= 1'h0;
    #1 check(rows[3]);
    finish_test();
  end
endmodule // testbench
